// File: hdl/csq_sequencer.sv
/*
 * Check shift sequencer top: AXI4-Lite slave holding the control/status,
 * data and check registers, the shift oscillator and shift control.
 * Word map: control/status at 0x0, data at 0x4, check at 0x8; any other
 * word answers a slave error, and a read of it returns zero.
 * Assumes one 25 MHz clock, synchronous active-low reset, and a master
 * that keeps at most one write and one read outstanding.
 * Assumes the host polls done before writing the next character; a data
 * write in mid-cycle restarts the count and keeps the partial check.
 */
// Functional notes
// - Counter presets only to zero or two
// - Load strobe presets counter; otherwise advances on shift pulses
// - Initialize clears all counter outputs
// - Data write loads and clears done on the same edge
// - Data write presets counter per mode
// - Shifting starts after write, done clear
// - Each shift pulse shifts data and check
// - Single character: wrap seven-to-zero sets done
// - Done stops free-running shifts (step pulses still shift), returns to load
// - Six-bit code stops after six pulses in single character mode
// - Word loading: halving stage doubles the count, sixteen shifts or twelve for six-bit code
// - Single character loads bus bits seven..zero
// - Mode bits configure feedback into check register
// - Quotient is data lsb xor check lsb
// - Feedback selector: double-complemented first, true second, both pass the true quotient
// - Shift enable cleared: one step per step bit
// - Clear bit zeroes check, sets done
module csq_sequencer
    import csq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [csq_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [csq_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [csq_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [csq_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [csq_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import csq_pkg::*;

    // Write channel holding state
    logic aw_got;
    logic w_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [AXI_DATA_W-1:0] w_data;
    logic [AXI_STRB_W-1:0] w_strb;
    logic wr_fire;
    logic wr_hit;
    logic csr_write;
    logic data_write;

    // Control state
    logic [MODE_W-1:0] mode;
    logic shift_enable;
    logic done;
    logic step_pulse;
    logic [WORD_W-1:0] data_reg;

    // Shift timing
    logic run;
    logic [1:0] div;
    logic shift_tick;
    logic shift_pulse;
    logic wrap;
    logic clear_pulse;

    // Network outputs
    logic [CHECK_W-1:0] check;
    logic quotient_bit;
    logic [AXI_DATA_W-1:0] read_word;
    logic read_hit;

    // Mode fields
    logic wide_check_select;
    logic longitudinal_select;
    logic variant_select;
    logic double_byte_select;

    assign wide_check_select = mode[BIT_WIDE];
    assign longitudinal_select = mode[BIT_LRC];
    assign variant_select = mode[BIT_VARIANT];
    assign double_byte_select = mode[BIT_DOUBLE];

    // A write is carried out once both address and data are held
    // Holding it off while bvalid stands keeps one response per write
    assign wr_fire = aw_got & w_got & ~s_axi_bvalid;
    assign wr_hit = (aw_addr == CSR_OFFSET) | (aw_addr == DATA_OFFSET)
        | (aw_addr == CHECK_OFFSET);
    // An all-zero strobe stores nothing and triggers nothing
    assign csr_write = wr_fire & (aw_addr == CSR_OFFSET) & w_strb[0];
    assign data_write = wr_fire & (aw_addr == DATA_OFFSET) & (|w_strb);
    assign clear_pulse = csr_write & w_data[BIT_CLEAR];

    // Address channel capture
    // Readies stay low from capture until the response is taken, so at most
    // one write is in flight and the held address cannot be overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_got <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_got <= 1'b0;
        end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Data channel capture, independent of address order
    // Either channel may arrive first; the write waits for both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_got <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_got <= 1'b0;
        end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Write response; unmapped addresses answer slave error
    // Response held until bready, whatever else the host does
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Mode and shift enable bits of the control register
    // Mode changes act at once, even in mid-cycle; software should only
    // change them while done is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= MODE_RESET;
            shift_enable <= SHIFT_EN_RESET;
        end else if (csr_write) begin
            mode <= w_data[MODE_W-1:0];
            shift_enable <= w_data[BIT_SHIFT_EN];
        end
    end

    // Step bit acts only with the newly written shift enable low
    // Registered, so the step lands after the write has been carried out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_pulse <= 1'b0;
        end else begin
            step_pulse <= csr_write & w_data[BIT_STEP] & ~w_data[BIT_SHIFT_EN];
        end
    end

    // Done flag: wrap or clear set it, a data write clears it; set wins
    // A wrap and a data write cannot meet: shifting is held off during the
    // write cycle, so the counter is always preset before its first pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done <= DONE_RESET;
        end else if (wrap || clear_pulse) begin
            done <= 1'b1;
        end else if (data_write) begin
            done <= 1'b0;
        end
    end

    // Oscillator runs only outside the write cycle and while not done
    // Shift enable low blocks the free-running pulses, not the step path
    assign run = shift_enable & ~done & ~data_write;

    // Free-running shift rate divided down from the system clock
    // 25 MHz over 10 MHz rounds down to every second clock, so shifting runs
    // a little faster than nominal; nothing outside depends on the rate
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            div <= 2'h0;
        end else if (div == SHIFT_DIV_LAST) begin
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
        end
    end

    assign shift_tick = run & (div == SHIFT_DIV_LAST);
    // Step pulses bypass the oscillator, as the diagnostic path does
    assign shift_pulse = shift_tick | step_pulse;

    // Data register: parallel load on write, shift right on each pulse
    // Byte mode zero-fills the upper half so no stale bits reach the quotient
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_reg <= DATA_RESET;
        end else if (data_write) begin
            if (double_byte_select) begin
                data_reg <= w_data[WORD_W-1:0];
            end else begin
                data_reg <= {{(WORD_W-CHAR_W){1'b0}}, w_data[CHAR_W-1:0]};
            end
        end else if (shift_pulse) begin
            data_reg <= data_reg >> 1;
        end
    end

    // Shift count: preset per mode on the data write strobe
    // Step pulses count as well, so single-stepping also ends in done
    csq_shift_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(data_write),
        .preset_six(short_char_mode(wide_check_select, longitudinal_select)),
        .pulse(shift_pulse),
        .double_byte(double_byte_select),
        .wrap(wrap)
    );

    // Check register and its feedback network
    // Clear has priority over a shift in the same cycle
    csq_check_net u_net (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(clear_pulse),
        .pulse(shift_pulse),
        .data_lsb(data_reg[0]),
        .wide(wide_check_select),
        .lrc(longitudinal_select),
        .variant(variant_select),
        .check(check),
        .quotient_bit(quotient_bit)
    );

    // Read decode; step and clear read back as zero
    // Decoded from the live address, which is held until arready is seen
    always_comb begin
        read_word = '0;
        read_hit = 1'b1;
        unique case (s_axi_araddr)
            CSR_OFFSET: begin
                read_word[MODE_W-1:0] = mode;
                read_word[BIT_SHIFT_EN] = shift_enable;
                read_word[BIT_DONE] = done;
                read_word[BIT_QUOTIENT] = quotient_bit;
            end
            DATA_OFFSET: read_word[WORD_W-1:0] = data_reg;
            CHECK_OFFSET: read_word[CHECK_W-1:0] = check;
            default: read_hit = 1'b0;
        endcase
    end

    // Read channel: one-cycle answer after the address is taken
    // Data registered with the address, so later shifts cannot alter a
    // pending answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// File: hdl/csq_pkg.sv
/*
 * Shared constants for the check shift sequencer: register map, control
 * field positions, reset values, counter presets, feedback masks, timing.
 * Assumes a single 25 MHz clock domain and an AXI4-Lite register bus.
 */
package csq_pkg;
    // Bus geometry
    localparam int AXI_ADDR_W = 4;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = AXI_DATA_W / 8;

    // Register byte offsets
    localparam logic [AXI_ADDR_W-1:0] CSR_OFFSET = 4'h0;
    localparam logic [AXI_ADDR_W-1:0] DATA_OFFSET = 4'h4;
    localparam logic [AXI_ADDR_W-1:0] CHECK_OFFSET = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control and status field positions
    localparam int BIT_WIDE = 0;
    localparam int BIT_LRC = 1;
    localparam int BIT_VARIANT = 2;
    localparam int BIT_DOUBLE = 3;
    localparam int BIT_CLEAR = 4;
    localparam int BIT_STEP = 5;
    localparam int BIT_SHIFT_EN = 6;
    localparam int BIT_DONE = 7;
    localparam int BIT_QUOTIENT = 8;
    localparam int MODE_W = 4;

    // Data paths
    localparam int CHAR_W = 8;
    localparam int WORD_W = 16;
    localparam int CHECK_W = 16;

    // Reset values
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam logic SHIFT_EN_RESET = 1'b1;
    localparam logic DONE_RESET = 1'b1;
    localparam logic [WORD_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [CHECK_W-1:0] CHECK_RESET = 16'h0000;

    // Shift counter presets: eight counts or six counts
    localparam logic [2:0] PRESET_EIGHT = 3'h0;
    localparam logic [2:0] PRESET_SIX = 3'h2;
    localparam logic [2:0] MOD8_LAST = 3'h7;

    // Feedback taps below the injection point, shift-right form
    localparam logic [CHECK_W-1:0] TAIL_CRC16 = 16'h2001;
    localparam logic [CHECK_W-1:0] TAIL_CCITT = 16'h0408;
    localparam logic [CHECK_W-1:0] TAIL_CRC12 = 16'h0701;
    localparam logic [CHECK_W-1:0] TAIL_NONE = 16'h0000;
    localparam int TOP_WIDE = 15;
    localparam int TOP_NARROW = 7;
    localparam int TOP_SHORT = 11;

    // Shift oscillator timing
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int SHIFT_FREQ_HZ = 10_000_000;
    localparam int SHIFT_DIV = CLK_FREQ_HZ / SHIFT_FREQ_HZ;
    localparam logic [1:0] SHIFT_DIV_LAST = 2'(SHIFT_DIV - 1);

    // Six-bit character code: neither wide nor longitudinal
    function automatic logic short_char_mode(input logic wide, input logic lrc);
        return ~wide & ~lrc;
    endfunction
endpackage

// File: hdl/csq_shift_counter.sv
/*
 * Presettable divide-by-2 / divide-by-8 shift counter that sets the number
 * of shifts per character. Assumes load and pulse are one-cycle strobes.
 */
module csq_shift_counter
    import csq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic preset_six,
    input wire logic pulse,
    input wire logic double_byte,
    output logic wrap
);
    import csq_pkg::*;

    logic half;
    logic [2:0] eighth;
    logic advance;

    // Word loading advances the eighth stage on falling half stage
    assign advance = pulse & (~double_byte | half);
    assign wrap = advance & (eighth == MOD8_LAST);

    // Divide-by-two stage; its preset input is tied low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half <= 1'b0;
        end else if (load) begin
            half <= 1'b0;
        end else if (pulse) begin
            half <= ~half;
        end
    end

    // Divide-by-eight stage, preset only to zero or two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eighth <= 3'h0;
        end else if (load) begin
            eighth <= preset_six ? PRESET_SIX : PRESET_EIGHT;
        end else if (advance) begin
            eighth <= eighth + 3'h1;
        end
    end
endmodule

// File: hdl/csq_check_net.sv
/*
 * Check register with its exclusive-OR and feedback network.
 * Assumes pulse is a one-cycle shift strobe and clear a one-cycle strobe.
 */
module csq_check_net
    import csq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic pulse,
    input wire logic data_lsb,
    input wire logic wide,
    input wire logic lrc,
    input wire logic variant,
    output logic [csq_pkg::CHECK_W-1:0] check,
    output logic quotient_bit
);
    import csq_pkg::*;

    logic feedback_mux_select;
    logic mux_out;
    logic [CHECK_W-1:0] tail;
    logic [CHECK_W-1:0] next_check;

    assign quotient_bit = data_lsb ^ check[0];
    assign feedback_mux_select = short_char_mode(wide, lrc);

    // Double-complemented first leg when select is one, true second leg otherwise; both pass the quotient
    assign mux_out = feedback_mux_select ? ~(~quotient_bit) : quotient_bit;

    // Tap pattern chosen from the mode bits
    always_comb begin
        if (lrc) begin
            tail = TAIL_NONE;
        end else if (!wide) begin
            tail = TAIL_CRC12;
        end else if (variant) begin
            tail = TAIL_CCITT;
        end else begin
            tail = TAIL_CRC16;
        end
    end

    // Shift right, fold the quotient into taps and injection point
    always_comb begin
        next_check = check >> 1;
        if (quotient_bit) begin
            next_check = next_check ^ tail;
        end
        if (feedback_mux_select) begin
            next_check[TOP_SHORT] = next_check[TOP_SHORT] ^ mux_out;
        end else if (wide) begin
            next_check[TOP_WIDE] = next_check[TOP_WIDE] ^ mux_out;
        end else begin
            next_check[TOP_NARROW] = next_check[TOP_NARROW] ^ mux_out;
        end
    end

    // Check register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            check <= CHECK_RESET;
        end else if (clear) begin
            check <= CHECK_RESET;
        end else if (pulse) begin
            check <= next_check;
        end
    end
endmodule

// File: verif/csq_monitor.sv
/*
 * Port checker for csq_sequencer: bus handshakes, response codes and
 * status read-back. Assumes one clock and a synchronous low reset.
 */
module csq_monitor
    import csq_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [csq_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [csq_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [csq_pkg::AXI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [csq_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [csq_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import csq_pkg::*;

    logic ar_bad, ar_csr, aw_bad;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Remember what kind of place each access went to
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_bad <= 1'b0;
            ar_csr <= 1'b0;
            aw_bad <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_bad <= !(s_axi_araddr inside {CSR_OFFSET, DATA_OFFSET, CHECK_OFFSET});
                ar_csr <= s_axi_araddr == CSR_OFFSET;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_bad <= !(s_axi_awaddr inside {CSR_OFFSET, DATA_OFFSET, CHECK_OFFSET});
            end
        end
    end

    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata)) else $error("read response dropped");
    w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2]
        s_axi_rvalid) else $error("read not answered");
    w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    bresp_code_a: assert property (s_axi_bvalid |->
        s_axi_bresp == (aw_bad ? RESP_SLVERR : RESP_OKAY)) else $error("bad bresp");
    rresp_code_a: assert property (s_axi_rvalid |->
        s_axi_rresp == (ar_bad ? RESP_SLVERR : RESP_OKAY)) else $error("bad rresp");
    csr_spare_a: assert property (s_axi_rvalid && ar_csr |-> s_axi_rdata[31:9] == 23'h0 &&
        s_axi_rdata[5:4] == 2'h0) else $error("status spare bits set");

    // Main scenarios
    cover property (s_axi_rvalid && ar_csr && s_axi_rdata[7]);
    cover property (s_axi_rvalid && ar_csr && !s_axi_rdata[7]);
    cover property (s_axi_bvalid && aw_bad);
endmodule

bind csq_sequencer csq_monitor u_csq_monitor (.*);

// File: verif/csq_host.sv
/*
 * Host model: an AXI4-Lite master offering write and read tasks.
 * Assumes the bench calls one task at a time; tout flags a hung wait.
 */
module csq_host (
    input wire logic aclk,
    output logic [3:0] s_axi_awaddr = 4'h0,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0] s_axi_wstrb = 4'hf,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [3:0] s_axi_araddr = 4'h0,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0,
    output logic tout = 1'b0
);
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        r = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 40) tout <= 1'b1;
    endtask

    // Read data is taken at the edge that sees rvalid
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        d = 32'h0;
        r = 2'h3;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 40) tout <= 1'b1;
    endtask
endmodule

// File: verif/tb_check_shift_sequencer.sv
/*
 * Bench for csq_sequencer: register access, step and cycle shifting for
 * three codes each, five codes in all, against a serial check model. Assumes csq_host as master.
 */
module tb_check_shift_sequencer
    import csq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] F_CLEAR = 32'h10, F_STEP = 32'h20;
    localparam logic [31:0] F_RUN = 32'h40, F_DONE = 32'h80;
    logic aclk = 1'b0, aresetn = 1'b0, tout;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0] mchk, mdat;
    int miscompares = 0, n_compared = 0;

    csq_sequencer u_csq_sequencer (.*);
    csq_host u_csq_host (.*);

    initial forever #20 aclk = ~aclk;

    task print_verdict();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        chk(nm, {30'h0, e}, {30'h0, g});
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        u_csq_host.wr(a, d, r);
        chk_resp("bresp", RESP_OKAY, r);
    endtask

    task rdc(input string nm, input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        u_csq_host.rd(a, v, r);
        chk_resp(nm, RESP_OKAY, r);
        chk(nm, e & m, v & m);
    endtask

    // Serial model of one shift and exclusive-OR step
    task shift(input logic [3:0] m);
        logic q;
        logic [15:0] t;
        q = mdat[0] ^ mchk[0];
        t = m[1] ? TAIL_NONE : (m[0] ? (m[2] ? TAIL_CCITT : TAIL_CRC16) : TAIL_CRC12);
        mchk = (mchk >> 1) ^ (q ? t : 16'h0);
        mchk[m[0] ? 15 : (m[1] ? 7 : 11)] ^= q;
        mdat = mdat >> 1;
    endtask

    function automatic int shifts(input logic [3:0] m);
        return ((m[0] | m[1]) ? 8 : 6) * (m[3] ? 2 : 1);
    endfunction

    task load(input logic [3:0] m, input logic [31:0] d);
        wr(DATA_OFFSET, d);
        mdat = m[3] ? d[15:0] : {8'h00, d[7:0]};
    endtask

    // Stepping shows the exact shift count and the quotient after each step
    task run_step(input logic [3:0] m, input logic [31:0] d);
        int n, i;
        n = shifts(m);
        wr(CSR_OFFSET, m | F_CLEAR);
        mchk = 16'h0;
        load(m, d);
        for (i = 0; i <= n; i++) begin
            if (i > 0) begin
                wr(CSR_OFFSET, m | F_STEP);
                shift(m);
            end
            rdc("csr", CSR_OFFSET, m | ((i == n) ? F_DONE : 0) | {mdat[0] ^ mchk[0], 8'h0},
                32'h1ff);
            rdc("check", CHECK_OFFSET, mchk, 32'hffff);
        end
    endtask

    // Free-running shifts, two characters accumulated per code
    task run_cycle(input logic [3:0] m, input logic [31:0] d);
        int n, i, k;
        n = shifts(m);
        wr(CSR_OFFSET, m | F_RUN | F_CLEAR);
        mchk = 16'h0;
        rdc("clear", CSR_OFFSET, m | F_RUN | F_DONE, 32'hff);
        for (i = 0; i < 2; i++) begin
            load(m, d ^ (i * 32'h5a5a));
            for (k = 0; k < 20; k++) begin
                u_csq_host.rd(CSR_OFFSET, v, r);
                if (v[7] === 1'b1) break;
            end
            chk("done_wait", 32'h1, {31'h0, k < 20});
            for (k = 0; k < n; k++) shift(m);
            rdc("done", CSR_OFFSET, m | F_RUN | F_DONE, 32'hff);
            rdc("check", CHECK_OFFSET, mchk, 32'hffff);
        end
    endtask

    // Hung handshake or runaway run ends the test
    always @(posedge tout) begin
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge aclk);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("csr0", CSR_OFFSET, 32'hc0, '1);
        rdc("data0", DATA_OFFSET, 32'h0, '1);
        rdc("check0", CHECK_OFFSET, 32'h0, '1);
        u_csq_host.rd(4'hc, v, r);
        chk_resp("rd_bad", RESP_SLVERR, r);
        u_csq_host.wr(4'hc, 32'h1, r);
        chk_resp("wr_bad", RESP_SLVERR, r);
        wr(CHECK_OFFSET, 32'hffff);
        rdc("check_ro", CHECK_OFFSET, 32'h0, '1);
        run_step(4'b0010, 32'hbeef_a5c3);
        run_step(4'b0000, 32'h0000_0ff2);
        run_step(4'b1001, 32'h0000_c3e1);
        run_cycle(4'b0101, 32'h0000_1234);
        run_cycle(4'b1011, 32'h0000_8001);
        run_cycle(4'b0001, 32'h0000_00a7);
        print_verdict();
    end
endmodule
